// ==== hw/eedmc_pkg.sv ====
// constants, types and register map of the nonvolatile data memory control
// assumes a 40 MHz core clock and the APB register bus of the core
package eedmc_pkg;
   // register indexes; byte address is four times the index
   localparam logic [9:0] CTRL_IDX = 10'h0D2;
   localparam logic [9:0] IST_IDX = 10'h0D3;
   localparam logic [9:0] IMSK_IDX = 10'h0D4;
   localparam int B_FLAG_OUT = 7;
   localparam int B_AUTO_ERASE = 6;
   localparam int B_PAGE_LOAD = 5;
   localparam int B_FLAG_EN = 4;
   localparam int B_INH = 3;
   localparam int B_ERR = 2;
   localparam int B_MAP = 1;
   localparam int B_BUSY = 0;
   localparam logic FLAG_OUT_RST = 1'b1;
   // interrupt status bits
   localparam int I_DONE = 0;
   localparam int I_ERR = 1;
   localparam int I_REFUSE = 2;
   localparam int IRQ_W = 3;
   // memory shape
   localparam int NV_AW = 12;
   localparam int PG_AW = 5;
   localparam logic [15:0] NV_TOP = 16'h0FFF;
   localparam logic [15:0] FLAG_LO = 16'h0780;
   localparam logic [15:0] FLAG_HI = 16'h07FF;
   localparam logic [7:0] ERASED = 8'hFF;
   // timing
   localparam int CLK_NS = 25;
   localparam int GUARD_NS = 2000000;
   localparam int GUARD_CYC = (GUARD_NS + CLK_NS - 1) / CLK_NS;
   localparam int PROG_CYC_DFLT = 2000;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_COMMIT = 2'b10,
      ST_CHIPER = 2'b11
   } eedmc_state_t;
endpackage

// ==== hw/eedmc_top.sv ====
// nonvolatile data memory control: control register, page buffer,
// programming sequencer, byte flags and array routing for the core
// assumes core data moves and serial port commands are on pclk
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module eedmc_top #(
   parameter int GUARD_CYC = eedmc_pkg::GUARD_CYC,
   parameter int PROG_CYC = eedmc_pkg::PROG_CYC_DFLT
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] xd_addr,
   input wire logic xd_rd,
   input wire logic xd_wr,
   input wire logic [7:0] xd_wdata,
   input wire logic xd_dptr,
   output logic nv_hit,
   output logic [7:0] nv_rdata,
   output logic nv_ack,
   input wire logic bod_pin,
   input wire logic keep_nv_fuse,
   input wire logic chip_erase_cmd,
   input wire logic flash_err_evt,
   output logic auto_erase_en,
   output logic irq
);
   localparam int CW = $clog2(GUARD_CYC + 1);
   localparam int PW = $clog2(PROG_CYC + 1);

   // address inside the byte-flag window
   function automatic logic in_flag_win(input logic [15:0] a);
      in_flag_win = (a >= eedmc_pkg::FLAG_LO) && (a <= eedmc_pkg::FLAG_HI);
   endfunction

   logic bod_m_q, bod_q, fuse_m_q, fuse_q;
   logic auto_erase_q, page_load_q, flag_en_q, err_q, map_q, flag_out_q;
   logic [eedmc_pkg::IRQ_W-1:0] ist_q, imsk_q;
   logic [CW-1:0] guard_q;
   logic [PW-1:0] prog_q;
   eedmc_pkg::eedmc_state_t st_q;
   logic [eedmc_pkg::PG_AW-1:0] idx_q;
   logic [eedmc_pkg::NV_AW-1:0] sweep_q;
   logic [6:0] page_q;
   logic [31:0] loaded_q;
   logic [127:0] flag_q;
   logic [7:0] pbuf [32];
   logic [7:0] mem [4096];
   logic [31:0] prdata_q;
   logic [7:0] nv_rdata_q;
   logic nv_ack_q;

   // pin-side inputs pass two flops before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bod_m_q <= 1'b0;
         bod_q <= 1'b0;
         fuse_m_q <= 1'b0;
         fuse_q <= 1'b0;
      end else begin
         bod_m_q <= bod_pin;
         bod_q <= bod_m_q;
         fuse_m_q <= keep_nv_fuse;
         fuse_q <= fuse_m_q;
      end
   end

   // write-block flag: high once 2 ms passed with no brown-out
   wire inhibit_ok = (guard_q == CW'(GUARD_CYC)) && !bod_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) guard_q <= '0;
      else if (bod_q) guard_q <= '0;
      else if (!inhibit_ok) guard_q <= guard_q + CW'(1);
   end

   // core data decode; 8-bit indirect moves never reach the array
   wire busy = (st_q != eedmc_pkg::ST_IDLE);
   wire in_nv = (xd_addr <= eedmc_pkg::NV_TOP);
   assign nv_hit = map_q && xd_dptr && in_nv;
   wire nv_wr = nv_hit && xd_wr && !busy;
   wire nv_rd = nv_hit && xd_rd && !busy;
   wire er_rd = !nv_hit && xd_rd && in_flag_win(xd_addr);
   wire er_wr = !nv_hit && xd_wr && in_flag_win(xd_addr);
   wire load = nv_wr && page_load_q;
   wire commit = nv_wr && !page_load_q;
   wire start = commit && inhibit_ok;
   wire refuse = commit && !inhibit_ok;
   wire chip_go = chip_erase_cmd && !busy && !fuse_q;
   wire abort = busy && bod_q;
   wire last = (idx_q == '1);
   wire mem_we = (st_q == eedmc_pkg::ST_COMMIT) && loaded_q[idx_q];
   wire sweep_last = (sweep_q == '1);

   // programming sequencer; erase and write are one timed step per page, then one buffer byte per cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= eedmc_pkg::ST_IDLE;
         prog_q <= '0;
         idx_q <= '0;
         sweep_q <= '0;
         page_q <= '0;
      end else if (abort) begin
         st_q <= eedmc_pkg::ST_IDLE;
      end else begin
         case (st_q)
            eedmc_pkg::ST_IDLE: begin
               prog_q <= '0;
               idx_q <= '0;
               sweep_q <= '0;
               if (chip_go) st_q <= eedmc_pkg::ST_CHIPER;
               else if (start) begin
                  st_q <= eedmc_pkg::ST_WAIT;
                  page_q <= xd_addr[11:5];
               end
            end
            eedmc_pkg::ST_WAIT: begin
               prog_q <= prog_q + PW'(1);
               if (prog_q == PW'(PROG_CYC - 1)) st_q <= eedmc_pkg::ST_COMMIT;
            end
            eedmc_pkg::ST_COMMIT: begin
               idx_q <= idx_q + 5'h01;
               if (last) st_q <= eedmc_pkg::ST_IDLE;
            end
            eedmc_pkg::ST_CHIPER: begin
               sweep_q <= sweep_q + 12'h001;
               if (sweep_last) st_q <= eedmc_pkg::ST_IDLE;
            end
            default: st_q <= eedmc_pkg::ST_IDLE;
         endcase
      end
   end

   // page buffer and its loaded mask; software loads each slot once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) loaded_q <= '0;
      else if (abort || (st_q == eedmc_pkg::ST_COMMIT && last)) loaded_q <= '0;
      else if (load || start) loaded_q[xd_addr[4:0]] <= 1'b1;
   end

   always_ff @(posedge pclk) begin
      if (load || start) pbuf[xd_addr[4:0]] <= xd_wdata;
   end

   // array: only loaded bytes rewritten; whole sweep only by serial port
   always_ff @(posedge pclk) begin
      if (mem_we) mem[{page_q, idx_q}] <= pbuf[idx_q];
      else if (st_q == eedmc_pkg::ST_CHIPER) mem[sweep_q] <= eedmc_pkg::ERASED;
   end

   // array read data, returned the cycle after the move
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nv_rdata_q <= 8'h00;
         nv_ack_q <= 1'b0;
      end else begin
         nv_ack_q <= nv_rd;
         if (nv_rd) nv_rdata_q <= mem[xd_addr[11:0]];
      end
   end
   assign nv_rdata = nv_rdata_q;
   assign nv_ack = nv_ack_q;

   // byte flags over the expanded-ram window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) flag_q <= '0;
      else if (!flag_en_q) flag_q <= '0;
      else if (er_wr) flag_q[xd_addr[6:0]] <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) flag_out_q <= eedmc_pkg::FLAG_OUT_RST;
      else if (!flag_en_q) flag_out_q <= 1'b1;
      else if (er_rd) flag_out_q <= flag_q[xd_addr[6:0]];
   end

   // register decode; unmapped words answer with an error
   wire acc = psel && penable;
   wire [9:0] ridx = paddr[11:2];
   wire al = (paddr[1:0] == 2'b00);
   wire s_ctrl = al && (ridx == eedmc_pkg::CTRL_IDX);
   wire s_ist = al && (ridx == eedmc_pkg::IST_IDX);
   wire s_imsk = al && (ridx == eedmc_pkg::IMSK_IDX);
   wire hit = s_ctrl || s_ist || s_imsk;
   wire wr = acc && pwrite && hit;
   wire w_ctrl = wr && s_ctrl;
   wire [7:0] ctrl_v = {flag_out_q, auto_erase_q, page_load_q, flag_en_q, inhibit_ok, err_q,
                        map_q, busy};
   wire [31:0] rd_v = s_ctrl ? {24'h000000, ctrl_v} :
                      s_ist ? {29'h00000000, ist_q} :
                      s_imsk ? {29'h00000000, imsk_q} : 32'h00000000;
   assign pready = 1'b1;
   assign pslverr = acc && !hit;
   assign prdata = prdata_q;

   // read data captured in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata_q <= 32'h00000000;
      else if (psel && !penable) prdata_q <= rd_v;
   end

   // control bits; the error flag set wins over a software clear
   wire err_set = abort || flash_err_evt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_erase_q <= 1'b0;
         page_load_q <= 1'b0;
         flag_en_q <= 1'b0;
         err_q <= 1'b0;
         map_q <= 1'b0;
      end else begin
         if (w_ctrl) begin
            auto_erase_q <= pwdata[eedmc_pkg::B_AUTO_ERASE];
            page_load_q <= pwdata[eedmc_pkg::B_PAGE_LOAD];
            flag_en_q <= pwdata[eedmc_pkg::B_FLAG_EN];
            map_q <= pwdata[eedmc_pkg::B_MAP];
         end
         if (err_set) err_q <= 1'b1;
         else if (w_ctrl && !pwdata[eedmc_pkg::B_ERR]) err_q <= 1'b0;
      end
   end
   // flash sequencer reads this to erase its page first
   assign auto_erase_en = auto_erase_q;

   // interrupt status, write one to clear, event wins
   wire [eedmc_pkg::IRQ_W-1:0] ev;
   assign ev[eedmc_pkg::I_DONE] = (st_q == eedmc_pkg::ST_COMMIT && last && !abort) ||
                                  (st_q == eedmc_pkg::ST_CHIPER && sweep_last && !abort);
   assign ev[eedmc_pkg::I_ERR] = err_set;
   assign ev[eedmc_pkg::I_REFUSE] = refuse;
   wire [eedmc_pkg::IRQ_W-1:0] w1c = (wr && s_ist) ? pwdata[2:0] : 3'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= '0;
         imsk_q <= '0;
      end else begin
         ist_q <= (ist_q & ~w1c) | ev;
         if (wr && s_imsk) imsk_q <= pwdata[2:0];
      end
   end
   assign irq = |(ist_q & imsk_q);

   // checks: all on pclk, all masked while reset is low
   // sequencer steps, named so the properties read like the walk
   sequence s_run;
      busy[*2];
   endsequence
   sequence s_done;
      (st_q == eedmc_pkg::ST_COMMIT) && last && !abort;
   endsequence
   sequence s_abort;
      busy && bod_q;
   endsequence

   // cycles spent busy; a commit takes the wait plus one buffer sweep
   // 32 bits wide so the long chip sweep can never wrap it
   logic [31:0] busy_len_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) busy_len_q <= 32'h00000000;
      else if (!busy) busy_len_q <= 32'h00000000;
      else busy_len_q <= busy_len_q + 32'h00000001;
   end

   chk_busy_start: assert property (@(posedge pclk) disable iff (!presetn)
      start |=> s_run) else $error("busy not raised at start");
   chk_busy_end: assert property (@(posedge pclk) disable iff (!presetn)
      s_done |=> !busy && ist_q[eedmc_pkg::I_DONE]) else $error("busy not cleared");
   chk_busy_length: assert property (@(posedge pclk) disable iff (!presetn)
      s_done |-> busy_len_q == 32'(PROG_CYC + (1 << eedmc_pkg::PG_AW) - 1))
      else $error("commit busy time wrong");
   chk_busy_ignore: assert property (@(posedge pclk) disable iff (!presetn)
      busy && xd_rd |=> !nv_ack) else $error("read during busy");
   chk_chip_erase: assert property (@(posedge pclk) disable iff (!presetn)
      chip_go && !abort |=> st_q == eedmc_pkg::ST_CHIPER) else $error("chip erase missed");
   chk_fuse_keep: assert property (@(posedge pclk) disable iff (!presetn)
      chip_erase_cmd && fuse_q && !busy |=> st_q != eedmc_pkg::ST_CHIPER)
      else $error("fused array swept");
   chk_sweep_source: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st_q == eedmc_pkg::ST_CHIPER) |-> $past(chip_erase_cmd))
      else $error("sweep without serial command");
   chk_chip_sweep: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == eedmc_pkg::ST_CHIPER |=> mem[$past(sweep_q)] == eedmc_pkg::ERASED)
      else $error("sweep left a byte");

   // checks: array contents and read path
   // limitation: array words never swept or written hold unknowns here
   chk_loaded_only: assert property (@(posedge pclk) disable iff (!presetn)
      (st_q == eedmc_pkg::ST_COMMIT) && !loaded_q[idx_q] |=>
      mem[{page_q, $past(idx_q)}] == $past(mem[{page_q, idx_q}]))
      else $error("unloaded byte written");
   chk_commit_write: assert property (@(posedge pclk) disable iff (!presetn)
      mem_we |=> mem[$past({page_q, idx_q})] == $past(pbuf[idx_q]))
      else $error("loaded byte not written");
   chk_read_data: assert property (@(posedge pclk) disable iff (!presetn)
      nv_rd |=> nv_ack && nv_rdata == $past(mem[xd_addr[11:0]]))
      else $error("array read lost");
   chk_short_ptr: assert property (@(posedge pclk) disable iff (!presetn)
      xd_rd && !xd_dptr |=> !nv_ack) else $error("short pointer hit array");
   chk_map_off: assert property (@(posedge pclk) disable iff (!presetn)
      !map_q && xd_rd |=> !nv_ack)
      else $error("array served with map clear");

   // checks: page buffer, write guard and error flag
   chk_no_load_start: assert property (@(posedge pclk) disable iff (!presetn)
      page_load_q && nv_wr |=> st_q == eedmc_pkg::ST_IDLE) else $error("load started write");
   chk_load_mark: assert property (@(posedge pclk) disable iff (!presetn)
      load |=> loaded_q[$past(xd_addr[4:0])])
      else $error("load slot not marked");
   chk_guard_block: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(bod_q) |=> !inhibit_ok[*8]) else $error("start not blocked");
   chk_refuse_idle: assert property (@(posedge pclk) disable iff (!presetn)
      refuse && !chip_go |=> !busy && ist_q[eedmc_pkg::I_REFUSE])
      else $error("refused write started");
   chk_err_set: assert property (@(posedge pclk) disable iff (!presetn)
      s_abort |=> err_q && !busy) else $error("error flag missed");
   chk_abort_drop: assert property (@(posedge pclk) disable iff (!presetn)
      s_abort |=> loaded_q == '0)
      else $error("buffer kept after brown-out");
   chk_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      err_q && !(w_ctrl && !pwdata[eedmc_pkg::B_ERR]) |=> err_q)
      else $error("error flag dropped");

   // checks: byte flags; the output settles one cycle after the enable falls
   chk_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !flag_en_q |=> flag_q == '0) else $error("flags not zero");
   chk_flag_out_one: assert property (@(posedge pclk) disable iff (!presetn)
      !flag_en_q && !$fell(flag_en_q) |-> ctrl_v[eedmc_pkg::B_FLAG_OUT])
      else $error("flag output not one");
   chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      flag_en_q && er_wr && !w_ctrl |=> flag_q[$past(xd_addr[6:0])]) else $error("flag not set");
   chk_flag_track: assert property (@(posedge pclk) disable iff (!presetn)
      flag_en_q && er_rd |=> flag_out_q == $past(flag_q[xd_addr[6:0]]))
      else $error("flag output not tracking");
endmodule
`default_nettype wire

// ==== dv/test_eeprom_data_memory_control.sv ====
// self-checking bench of the nonvolatile data memory control block
// assumes hw/eedmc_pkg.sv and hw/eedmc_top.sv compiled first; bench drives every port
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_data_memory_control;
   localparam logic [11:0] A_CTRL = {eedmc_pkg::CTRL_IDX, 2'b00};
   localparam logic [11:0] A_IST = {eedmc_pkg::IST_IDX, 2'b00};
   localparam logic [11:0] A_IMSK = {eedmc_pkg::IMSK_IDX, 2'b00};
   typedef struct {bit on; logic [31:0] v;} eedmc_exp_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] xd_addr = 16'h0000;
   logic xd_rd = 1'b0, xd_wr = 1'b0, xd_dptr = 1'b0, nv_hit, nv_ack, auto_erase_en, irq;
   logic [7:0] xd_wdata = 8'h00, nv_rdata, b;
   logic bod_pin = 1'b0, keep_nv_fuse = 1'b0, chip_erase_cmd = 1'b0, flash_err_evt = 1'b0;
   int fails = 0, checked = 0;
   int seed = 32'h1E88;
   eedmc_exp_t q_apb[$];
   logic [7:0] q_nv[$];

   // short guard and program counts keep the run brief
   eedmc_top #(.GUARD_CYC(20), .PROG_CYC(4)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .xd_addr(xd_addr),
      .xd_rd(xd_rd), .xd_wr(xd_wr), .xd_wdata(xd_wdata), .xd_dptr(xd_dptr),
      .nv_hit(nv_hit), .nv_rdata(nv_rdata), .nv_ack(nv_ack), .bod_pin(bod_pin),
      .keep_nv_fuse(keep_nv_fuse), .chip_erase_cmd(chip_erase_cmd),
      .flash_err_evt(flash_err_evt), .auto_erase_en(auto_erase_en), .irq(irq));

   initial forever #12.5 pclk = ~pclk;

   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic give_verdict;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // one apb transfer; a read notes its expectation for the monitor
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         input bit on, output logic [31:0] r);
      if (!w) q_apb.push_back('{on, d});
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= w ? d : $random(seed);
      @(posedge pclk);
      penable <= 1'b1;
      // no local limit: only the watchdog ends a wait for pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, 1'b0, r);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, e, 1'b1, r);
   endtask

   // polls are bounded; a slow busy flag shows as a mismatch
   task automatic wait_bit(input int k, input logic v);
      logic [31:0] r;
      int n;
      n = 0;
      do begin
         apb(1'b0, A_CTRL, 32'h0, 1'b0, r);
         n++;
      end while (r[k] !== v && n < 3000);
      check("ctrl poll", {31'h0, v}, {31'h0, r[k]});
   endtask

   // one core data move, checks the array decode at the taking edge
   task automatic mv(input logic w, input logic [15:0] a, input logic [7:0] d,
         input logic dp, input logic hit);
      @(posedge pclk);
      xd_addr <= a;
      xd_wr <= w;
      xd_rd <= !w;
      xd_wdata <= d;
      xd_dptr <= dp;
      @(posedge pclk);
      check("nv_hit", {31'h0, hit}, {31'h0, nv_hit});
      xd_rd <= 1'b0;
      xd_wr <= 1'b0;
   endtask

   task automatic rd_nv(input logic [15:0] a, input logic [7:0] e);
      q_nv.push_back(e);
      mv(1'b0, a, 8'h00, 1'b1, 1'b1);
   endtask

   task automatic pulse(input int which);
      @(posedge pclk);
      if (which == 0) chip_erase_cmd <= 1'b1;
      else flash_err_evt <= 1'b1;
      @(posedge pclk);
      chip_erase_cmd <= 1'b0;
      flash_err_evt <= 1'b0;
   endtask

   // monitor: oldest note against each result as it appears
   always @(posedge pclk) begin
      eedmc_exp_t e;
      if (psel && penable && pready) begin
         check("pslverr", {31'h0, !(paddr inside {A_CTRL, A_IST, A_IMSK})},
               {31'h0, pslverr});
         if (!pwrite && q_apb.size() > 0) begin
            e = q_apb.pop_front();
            if (e.on) check("prdata", e.v, prdata);
         end
      end
      if (nv_ack === 1'b1) begin
         if (q_nv.size() == 0) check("nv_ack", 32'h0, 32'h1);
         else check("nv_rdata", {24'h0, q_nv.pop_front()}, {24'h0, nv_rdata});
      end
   end

   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      give_verdict;
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_CTRL, 32'h80);
      rd(12'h100, 32'h0);
      wr(A_CTRL, 32'h02);
      mv(1'b1, 16'h0010, 8'h77, 1'b1, 1'b1);
      rd(A_IST, 32'h4);
      wr(A_IST, 32'h7);
      wait_bit(eedmc_pkg::B_INH, 1'b1);
      pulse(0);
      rd(A_CTRL, 32'h8B);
      wait_bit(eedmc_pkg::B_BUSY, 1'b0);
      rd_nv(16'h0FFF, 8'hFF);
      wr(A_IST, 32'h7);
      wr(A_IMSK, 32'h1);
      b = 8'($random(seed));
      mv(1'b1, 16'h0040, b, 1'b1, 1'b1);
      rd(A_CTRL, 32'h8B);
      mv(1'b0, 16'h0040, 8'h00, 1'b1, 1'b1);
      @(negedge pclk);
      check("irq idle", 32'h0, {31'h0, irq});
      wait_bit(eedmc_pkg::B_BUSY, 1'b0);
      @(negedge pclk);
      check("irq done", 32'h1, {31'h0, irq});
      rd_nv(16'h0040, b);
      wr(A_IST, 32'h7);
      @(negedge pclk);
      check("irq clear", 32'h0, {31'h0, irq});
      wr(A_CTRL, 32'h42);
      @(negedge pclk);
      check("auto_erase_en", 32'h1, {31'h0, auto_erase_en});
      // page load then commit; unloaded slot must stay erased
      wr(A_CTRL, 32'h22);
      mv(1'b1, 16'h00A1, 8'h11, 1'b1, 1'b1);
      mv(1'b1, 16'h00A2, 8'h22, 1'b1, 1'b1);
      rd(A_CTRL, 32'hAA);
      wr(A_CTRL, 32'h02);
      mv(1'b1, 16'h00A5, 8'h55, 1'b1, 1'b1);
      wait_bit(eedmc_pkg::B_BUSY, 1'b0);
      rd_nv(16'h00A1, 8'h11);
      rd_nv(16'h00A2, 8'h22);
      rd_nv(16'h00A5, 8'h55);
      rd_nv(16'h00A3, 8'hFF);
      mv(1'b0, 16'h0040, 8'h00, 1'b0, 1'b0);
      mv(1'b0, 16'h1000, 8'h00, 1'b1, 1'b0);
      wr(A_CTRL, 32'h00);
      mv(1'b0, 16'h0040, 8'h00, 1'b1, 1'b0);
      // byte flags at both ends of the window
      wr(A_CTRL, 32'h10);
      mv(1'b1, 16'h07FF, 8'h3C, 1'b0, 1'b0);
      mv(1'b0, 16'h07FF, 8'h00, 1'b0, 1'b0);
      rd(A_CTRL, 32'h98);
      mv(1'b0, 16'h0780, 8'h00, 1'b0, 1'b0);
      rd(A_CTRL, 32'h18);
      wr(A_CTRL, 32'h00);
      rd(A_CTRL, 32'h88);
      wr(A_CTRL, 32'h10);
      mv(1'b0, 16'h07FF, 8'h00, 1'b0, 1'b0);
      rd(A_CTRL, 32'h18);
      wr(A_CTRL, 32'h00);
      pulse(1);
      rd(A_CTRL, 32'h8C);
      rd(A_IST, 32'h3);
      wr(A_CTRL, 32'h04);
      rd(A_CTRL, 32'h8C);
      wr(A_CTRL, 32'h00);
      rd(A_CTRL, 32'h88);
      // fuse kept: chip erase must spare the array
      keep_nv_fuse <= 1'b1;
      wr(A_CTRL, 32'h02);
      pulse(0);
      wait_bit(eedmc_pkg::B_BUSY, 1'b0);
      rd_nv(16'h00A1, 8'h11);
      // recent brown-out blocks a start
      bod_pin <= 1'b1;
      repeat (5) @(posedge pclk);
      bod_pin <= 1'b0;
      repeat (3) @(posedge pclk);
      wr(A_IST, 32'h7);
      mv(1'b1, 16'h0050, 8'h66, 1'b1, 1'b1);
      rd(A_IST, 32'h4);
      // brown-out inside the wait: abort, error set, byte never written
      wr(A_IST, 32'h7);
      wait_bit(eedmc_pkg::B_INH, 1'b1);
      mv(1'b1, 16'h0050, 8'h66, 1'b1, 1'b1);
      bod_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      bod_pin <= 1'b0;
      wait_bit(eedmc_pkg::B_BUSY, 1'b0);
      rd(A_CTRL, 32'h86);
      rd(A_IST, 32'h2);
      rd_nv(16'h0050, 8'hFF);
      repeat (4) @(posedge pclk);
      check("queues empty", 32'h0, q_nv.size() + q_apb.size());
      give_verdict;
   end
endmodule
`default_nettype wire
